// File: design/sfc_pkg.sv
// Shared constants of the self-programming flash controller
package sfc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned ROW_WORDS   = 64;   // Instructions per row
    localparam int unsigned ROW_BYTES   = 192;  // Bytes per row
    localparam int unsigned PAGE_WORDS  = 512;  // Instructions per erase page
    localparam int unsigned PAGE_BYTES  = 1536; // Bytes per erase page
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned WORD_W      = 24;
    localparam int unsigned IDX_W       = 6;
    localparam logic [ADDR_W-1:0] ROW_MASK  = 24'h00007f; // Two address units per instruction
    localparam logic [ADDR_W-1:0] PAGE_MASK = 24'h0003ff;

    // ------------------------------------------------------------
    // Special-function register selects
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_CTRL = 2'h0;   // flash_operation_control
    localparam logic [1:0] SEL_KEY  = 2'h1;   // unlock_key_register
    localparam logic [1:0] SEL_PAGE = 2'h2;   // table_page_register

    // ------------------------------------------------------------
    // Control register layout and values
    // ------------------------------------------------------------
    localparam int unsigned CTL_START = 15;
    localparam int unsigned CTL_WRITE_ENABLE_BIT  = 14;
    localparam int unsigned CTL_ERR   = 13;
    localparam int unsigned CTL_ERASE = 6;
    localparam int unsigned CTL_OP_HI = 3;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [3:0]  OP_ROW    = 4'h1;
    localparam logic [3:0]  OP_ERASE  = 4'h2;
    localparam logic [3:0]  OP_WORD   = 4'h3;
    localparam logic [7:0]  KEY_FIRST = 8'h55;
    localparam logic [7:0]  KEY_SECOND = 8'haa;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_RDREQ = 6'b000010,
        ST_RDCAP = 6'b000100,
        ST_LOAD  = 6'b001000,
        ST_XFER  = 6'b010000,
        ST_WAIT  = 6'b100000
    } sfc_state_e;

    // Unlock progress
    typedef enum logic [2:0] {
        UK_NONE  = 3'b001,
        UK_FIRST = 3'b010,
        UK_BOTH  = 3'b100
    } sfc_key_e;

endpackage

// File: design/sfc_latch_mem.sv
// Write latch memory holding one row of program words
`timescale 1ns/1ps
module sfc_latch_mem #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned WIDTH = 24,
    parameter int unsigned AW    = 6
) (
    // Clock
    input  wire logic             clk_i,
    // Write port with byte enables
    input  wire logic             we_i,
    input  wire logic [2:0]       be_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Registered read port
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);

    // ------------------------------------------------------------
    // Per-byte storage
    // ------------------------------------------------------------
    // Each lane owns its array and read register, so one process drives each
    genvar b;
    generate
        for (b = 0; b < WIDTH / 8; b++) begin : g_byte
            logic [7:0] mem [DEPTH];
            logic [7:0] rd_r;
            always_ff @(posedge clk_i) begin
                if (we_i && be_i[b]) begin
                    mem[waddr_i] <= wdata_i[b*8 +: 8];
                end
                rd_r <= mem[raddr_i];
            end
            // Read data out of a register
            assign rdata_o[b*8 +: 8] = rd_r;
        end
    endgenerate

endmodule

// File: design/sfc_flash_ctrl.sv
// Run-time self-programming flash controller top level
`timescale 1ns/1ps
module sfc_flash_ctrl
    import sfc_pkg::*;
(
    // Clock and reset
    input  wire logic                      REF_CLK_I,
    input  wire logic                      RST_N_I,
    // Special-function register writes and read-back
    input  wire logic                      SFR_WE_I,
    input  wire logic [1:0]                SFR_SEL_I,
    input  wire logic [15:0]               SFR_WDATA_I,
    output logic      [15:0]               CTRL_RDATA_O,
    output logic      [7:0]                PAGE_RDATA_O,
    // Table access from the core
    input  wire logic                      TBL_REQ_I,
    input  wire logic                      TBL_WRITE_I,
    input  wire logic                      TBL_HIGH_I,
    input  wire logic                      TBL_BYTE_I,
    input  wire logic [15:0]               TBL_EA_I,
    input  wire logic [15:0]               TBL_WDATA_I,
    output logic      [15:0]               TBL_RDATA_O,
    output logic                           TBL_ACK_O,
    output logic                           CPU_STALL_O,
    // Flash array side
    output logic      [sfc_pkg::ADDR_W-1:0] FL_ADDR_O,
    output logic                           FL_RD_O,
    input  wire logic [sfc_pkg::WORD_W-1:0] FL_RDATA_I,
    output logic                           FL_WSTB_O,
    output logic      [sfc_pkg::WORD_W-1:0] FL_WDATA_O,
    output logic                           FL_ERASE_O,
    output logic                           FL_PROG_O,
    input  wire logic                      FL_DONE_I
);

    import sfc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sfc_state_e             state_r, state_nxt;
    sfc_key_e               key_r, key_nxt;
    logic [15:0]            ctrl_r, ctrl_nxt;
    logic [7:0]             page_r, page_nxt;
    logic [ADDR_W-1:0]      base_r, base_nxt;
    logic [IDX_W-1:0]       idx_r, idx_nxt;
    logic                   last_r, last_nxt;
    logic [15:0]            rdata_r, rdata_nxt;
    logic                   ack_r, ack_nxt;
    logic                   stall_r, stall_nxt;
    logic [ADDR_W-1:0]      faddr_r, faddr_nxt;
    logic                   frd_r, frd_nxt;
    logic                   fwstb_r, fwstb_nxt;
    logic                   ferase_r, ferase_nxt;
    logic                   fprog_r, fprog_nxt;
    logic                   rd_high_r, rd_high_nxt;
    logic                   rd_odd_r, rd_odd_nxt;
    logic                   rd_byte_r, rd_byte_nxt;

    // Latch memory ports
    logic                   lm_we;
    logic [2:0]             lm_be;
    logic [WORD_W-1:0]      lm_wdata;
    logic [IDX_W-1:0]       lm_raddr;
    logic [WORD_W-1:0]      lm_rdata;

    // Decode helpers
    logic [ADDR_W-1:0]      tbl_addr;
    logic                   any_access;
    logic                   start_req;
    logic                   op_erase;
    logic                   op_row;
    logic                   op_word;

    // ------------------------------------------------------------
    // Address and request decode
    // ------------------------------------------------------------
    // page joined with effective address
    assign tbl_addr   = {page_r, TBL_EA_I};
    assign any_access = SFR_WE_I || TBL_REQ_I;
    assign start_req  = SFR_WE_I && (SFR_SEL_I == SEL_CTRL) && SFR_WDATA_I[CTL_START];
    assign op_erase   = (SFR_WDATA_I[CTL_OP_HI:0] == OP_ERASE) && SFR_WDATA_I[CTL_ERASE];
    assign op_row     = (SFR_WDATA_I[CTL_OP_HI:0] == OP_ROW) && !SFR_WDATA_I[CTL_ERASE];
    assign op_word    = (SFR_WDATA_I[CTL_OP_HI:0] == OP_WORD) && !SFR_WDATA_I[CTL_ERASE];

    // Latch write lanes
    // high lane, low word or low byte lanes
    always_comb begin
        lm_wdata = '0;
        lm_be    = 3'h0;
        if (TBL_HIGH_I) begin
            lm_wdata = {TBL_WDATA_I[7:0], 16'h0000};
            lm_be    = (TBL_BYTE_I && TBL_EA_I[0]) ? 3'h0 : 3'h4;
        end else if (!TBL_BYTE_I) begin
            lm_wdata = {8'h00, TBL_WDATA_I};
            lm_be    = 3'h3;
        end else begin
            lm_wdata = {8'h00, TBL_WDATA_I[7:0], TBL_WDATA_I[7:0]};
            lm_be    = TBL_EA_I[0] ? 3'h2 : 3'h1;
        end
    end

    // table writes fill the latches, ignored while busy
    // no latch update during a cycle
    assign lm_we = (state_r == ST_IDLE) && TBL_REQ_I && TBL_WRITE_I;

    // Latch memory, word index from even instruction addresses
    sfc_latch_mem #(
        .DEPTH (ROW_WORDS),
        .WIDTH (WORD_W),
        .AW    (IDX_W)
    ) u_latch (
        .clk_i   (REF_CLK_I),
        .we_i    (lm_we),
        .be_i    (lm_be),
        .waddr_i (TBL_EA_I[IDX_W:1]),
        .wdata_i (lm_wdata),
        .raddr_i (lm_raddr),
        .rdata_o (lm_rdata)
    );
    assign lm_raddr = idx_r;

    // ------------------------------------------------------------
    // Next-state logic of the sequencer and registers
    // ------------------------------------------------------------
    always_comb begin
        state_nxt   = state_r;
        key_nxt     = key_r;
        ctrl_nxt    = ctrl_r;
        page_nxt    = page_r;
        base_nxt    = base_r;
        idx_nxt     = idx_r;
        last_nxt    = last_r;
        rdata_nxt   = rdata_r;
        ack_nxt     = 1'b0;
        stall_nxt   = stall_r;
        faddr_nxt   = faddr_r;
        frd_nxt     = 1'b0;
        fwstb_nxt   = 1'b0;
        ferase_nxt  = ferase_r;
        fprog_nxt   = fprog_r;
        rd_high_nxt = rd_high_r;
        rd_odd_nxt  = rd_odd_r;
        rd_byte_nxt = rd_byte_r;

        // any access other than the expected one drops the unlock
        if (any_access) begin
            key_nxt = UK_NONE;
        end
        if (SFR_WE_I && (SFR_SEL_I == SEL_KEY) && (state_r == ST_IDLE)) begin
            if (SFR_WDATA_I[7:0] == KEY_FIRST) begin
                key_nxt = UK_FIRST;
            end else if ((SFR_WDATA_I[7:0] == KEY_SECOND) && (key_r == UK_FIRST)) begin
                key_nxt = UK_BOTH;
            end
        end

        case (state_r)
            ST_IDLE: begin
                // Plain register writes
                if (SFR_WE_I && (SFR_SEL_I == SEL_PAGE)) begin
                    page_nxt = SFR_WDATA_I[7:0];
                end
                if (SFR_WE_I && (SFR_SEL_I == SEL_CTRL) && !start_req) begin
                    ctrl_nxt[CTL_WRITE_ENABLE_BIT]       = SFR_WDATA_I[CTL_WRITE_ENABLE_BIT];
                    ctrl_nxt[CTL_ERR]        = SFR_WDATA_I[CTL_ERR] & ctrl_r[CTL_ERR];
                    ctrl_nxt[CTL_ERASE]      = SFR_WDATA_I[CTL_ERASE];
                    ctrl_nxt[CTL_OP_HI:0]    = SFR_WDATA_I[CTL_OP_HI:0];
                end
                // start only when armed and enabled
                if (start_req) begin
                    ctrl_nxt[CTL_WRITE_ENABLE_BIT]    = SFR_WDATA_I[CTL_WRITE_ENABLE_BIT];
                    ctrl_nxt[CTL_ERASE]   = SFR_WDATA_I[CTL_ERASE];
                    ctrl_nxt[CTL_OP_HI:0] = SFR_WDATA_I[CTL_OP_HI:0];
                    if ((key_r == UK_BOTH) && SFR_WDATA_I[CTL_WRITE_ENABLE_BIT]) begin
                        if (op_erase) begin
                            ctrl_nxt[CTL_START] = 1'b1;
                            ctrl_nxt[CTL_ERR]   = 1'b0;
                            stall_nxt           = 1'b1;
                            faddr_nxt           = base_r & ~PAGE_MASK;
                            ferase_nxt          = 1'b1;
                            fprog_nxt           = 1'b1;
                            state_nxt           = ST_WAIT;
                        end else if (op_row || op_word) begin
                            // row streams all latches, word streams one
                            ctrl_nxt[CTL_START] = 1'b1;
                            ctrl_nxt[CTL_ERR]   = 1'b0;
                            stall_nxt           = 1'b1;
                            idx_nxt             = op_word ? base_r[IDX_W:1] : '0;
                            last_nxt            = op_word;
                            state_nxt           = ST_LOAD;
                        end else begin
                            ctrl_nxt[CTL_ERR] = 1'b1;
                        end
                    end
                end
                // Table requests
                if (TBL_REQ_I) begin
                    if (TBL_WRITE_I) begin
                        // last written address is the operation base
                        base_nxt = tbl_addr;
                        ack_nxt  = 1'b1;
                    end else begin
                        faddr_nxt   = {tbl_addr[ADDR_W-1:1], 1'b0};
                        frd_nxt     = 1'b1;
                        rd_high_nxt = TBL_HIGH_I;
                        rd_odd_nxt  = TBL_EA_I[0];
                        rd_byte_nxt = TBL_BYTE_I;
                        state_nxt   = ST_RDREQ;
                    end
                end
            end
            ST_RDREQ: begin
                state_nxt = ST_RDCAP;
            end
            ST_RDCAP: begin
                if (rd_high_r) begin
                    rdata_nxt = (rd_byte_r && rd_odd_r) ? 16'h0000 : {8'h00, FL_RDATA_I[23:16]};
                end else if (!rd_byte_r) begin
                    rdata_nxt = FL_RDATA_I[15:0];
                end else begin
                    rdata_nxt = rd_odd_r ? {8'h00, FL_RDATA_I[15:8]} : {8'h00, FL_RDATA_I[7:0]};
                end
                ack_nxt   = 1'b1;
                state_nxt = ST_IDLE;
            end
            ST_LOAD: begin
                // Latch read issued, data valid next cycle
                state_nxt = ST_XFER;
            end
            ST_XFER: begin
                // move one latch word into the array
                fwstb_nxt = 1'b1;
                faddr_nxt = (base_r & ~ROW_MASK) | {{(ADDR_W-IDX_W-1){1'b0}}, idx_r, 1'b0};
                if (last_r || (idx_r == IDX_W'(ROW_WORDS - 1))) begin
                    fprog_nxt = 1'b1;
                    state_nxt = ST_WAIT;
                end else begin
                    idx_nxt   = idx_r + 1'b1;
                    state_nxt = ST_LOAD;
                end
            end
            ST_WAIT: begin
                if (FL_DONE_I && !fwstb_r) begin
                    ctrl_nxt[CTL_START] = 1'b0;
                    stall_nxt           = 1'b0;
                    fprog_nxt           = 1'b0;
                    ferase_nxt          = 1'b0;
                    state_nxt           = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state_r   <= ST_IDLE;
            key_r     <= UK_NONE;
            ctrl_r    <= CTL_RESET;
            page_r    <= '0;
            base_r    <= '0;
            idx_r     <= '0;
            last_r    <= 1'b0;
            rdata_r   <= '0;
            ack_r     <= 1'b0;
            stall_r   <= 1'b0;
            faddr_r   <= '0;
            frd_r     <= 1'b0;
            fwstb_r   <= 1'b0;
            ferase_r  <= 1'b0;
            fprog_r   <= 1'b0;
            rd_high_r <= 1'b0;
            rd_odd_r  <= 1'b0;
            rd_byte_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            key_r     <= key_nxt;
            ctrl_r    <= ctrl_nxt;
            page_r    <= page_nxt;
            base_r    <= base_nxt;
            idx_r     <= idx_nxt;
            last_r    <= last_nxt;
            rdata_r   <= rdata_nxt;
            ack_r     <= ack_nxt;
            stall_r   <= stall_nxt;
            faddr_r   <= faddr_nxt;
            frd_r     <= frd_nxt;
            fwstb_r   <= fwstb_nxt;
            ferase_r  <= ferase_nxt;
            fprog_r   <= fprog_nxt;
            rd_high_r <= rd_high_nxt;
            rd_odd_r  <= rd_odd_nxt;
            rd_byte_r <= rd_byte_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign CTRL_RDATA_O = ctrl_r;
    assign PAGE_RDATA_O = page_r;
    assign TBL_RDATA_O  = rdata_r;
    assign TBL_ACK_O    = ack_r;
    assign CPU_STALL_O  = stall_r;
    assign FL_ADDR_O    = faddr_r;
    assign FL_RD_O      = frd_r;
    assign FL_WSTB_O    = fwstb_r;
    assign FL_WDATA_O   = lm_rdata;
    assign FL_ERASE_O   = ferase_r;
    assign FL_PROG_O    = fprog_r;

endmodule

// File: test/sfc_flash_ctrl_assertions.sv
// Port-level assertion checker for the flash controller
`timescale 1ns/1ps
module sfc_chk_assertions
    import sfc_pkg::*;
(
    // Clock and reset
    input wire logic        REF_CLK_I,
    input wire logic        RST_N_I,
    // Register and table side
    input wire logic        SFR_WE_I,
    input wire logic [1:0]  SFR_SEL_I,
    input wire logic [15:0] SFR_WDATA_I,
    input wire logic [15:0] CTRL_RDATA_O,
    input wire logic [7:0]  PAGE_RDATA_O,
    input wire logic        TBL_REQ_I,
    input wire logic        TBL_WRITE_I,
    input wire logic        TBL_ACK_O,
    input wire logic        CPU_STALL_O,
    // Array side
    input wire logic [23:0] FL_ADDR_O,
    input wire logic        FL_RD_O,
    input wire logic        FL_WSTB_O,
    input wire logic        FL_ERASE_O,
    input wire logic        FL_PROG_O,
    input wire logic        FL_DONE_I
);
    default clocking dc @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    chk_read_ack: assert property (FL_RD_O |=> !FL_RD_O ##1 TBL_ACK_O)
        else $error("Table read not answered in time");
    chk_write_ack: assert property (TBL_REQ_I && TBL_WRITE_I && !CPU_STALL_O && !FL_RD_O
        && !$past(FL_RD_O) |=> TBL_ACK_O) else $error("Table write not acknowledged");
    chk_no_start: assert property (SFR_WE_I && SFR_SEL_I == SEL_CTRL && !CPU_STALL_O
        && !(SFR_WDATA_I[CTL_START] && SFR_WDATA_I[CTL_WRITE_ENABLE_BIT]) |=> !CPU_STALL_O) else $error("Unarmed start");
    chk_busy_bit: assert property (CPU_STALL_O |-> CTRL_RDATA_O[CTL_START] && !TBL_ACK_O)
        else $error("Busy without start bit or with ack");
    chk_done_release: assert property (CPU_STALL_O && FL_PROG_O && FL_DONE_I && !FL_WSTB_O
        |=> !CPU_STALL_O && !FL_PROG_O && !CTRL_RDATA_O[CTL_START]) else $error("Cycle not closed");
    chk_erase_page: assert property (FL_ERASE_O |-> FL_PROG_O && FL_ADDR_O[9:0] == 10'h000)
        else $error("Erase not page aligned");
    chk_strobe_step: assert property (FL_WSTB_O && !FL_PROG_O |=> !FL_WSTB_O ##1
        (FL_WSTB_O && FL_ADDR_O == $past(FL_ADDR_O, 2) + 24'h000002)) else $error("Row strobe step wrong");
    chk_page_hold: assert property (CPU_STALL_O && $past(CPU_STALL_O) |-> $stable(PAGE_RDATA_O))
        else $error("Page changed while busy");

    cov_erase: cover property (FL_ERASE_O && FL_DONE_I);
    cov_row_end: cover property (FL_WSTB_O && FL_PROG_O);
    cov_bad_op: cover property (CTRL_RDATA_O[CTL_ERR]);
endmodule

bind sfc_flash_ctrl sfc_chk_assertions u_chk (
    .REF_CLK_I, .RST_N_I, .SFR_WE_I, .SFR_SEL_I, .SFR_WDATA_I, .CTRL_RDATA_O, .PAGE_RDATA_O, .TBL_REQ_I,
    .TBL_WRITE_I, .TBL_ACK_O, .CPU_STALL_O, .FL_ADDR_O, .FL_RD_O, .FL_WSTB_O, .FL_ERASE_O, .FL_PROG_O, .FL_DONE_I
);

// File: test/sfc_flash_model.sv
// Behavioural flash array facing the controller's array port
`timescale 1ns/1ps
module sfc_flash_model (
    // Clock
    input  wire logic        clk_i,
    // Requests from the controller, busy time from the bench
    input  wire logic [23:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic        wstb_i,
    input  wire logic [23:0] wdata_i,
    input  wire logic        erase_i,
    input  wire logic        prog_i,
    input  wire logic [7:0]  busy_i,
    // Answers to the controller
    output logic      [23:0] rdata_o,
    output logic             done_o
);
    logic [23:0] mem [int];
    logic [7:0]  cnt;

    initial begin
        rdata_o = 24'h000000;
        done_o = 1'b0;
        cnt = 8'h00;
    end

    // Read answer next cycle, data wanders otherwise; done busy_i+1 cycles after prog_i rises
    always @(posedge clk_i) begin
        rdata_o <= rd_i ? (mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 24'hffffff) : ~rdata_o;
        if (wstb_i) begin
            mem[int'(addr_i)] = wdata_i;
        end
        if (erase_i && prog_i && cnt == 8'h00) begin
            for (int i = 0; i < 1024; i += 2) mem.delete(int'({addr_i[23:10], 10'h000}) + i);
        end
        cnt <= prog_i ? cnt + 8'h01 : 8'h00;
        done_o <= prog_i && cnt >= busy_i;
    end
endmodule

// File: test/test_selfprog_flash_controller.sv
// Self-checking bench for the self-programming flash controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("Error %s expected %h seen %h", nm, e, g); end end
module test_selfprog_flash_controller;
    import sfc_pkg::*;
    logic        clk, rst_n, sfr_we, tbl_req, tbl_write, tbl_high, tbl_byte;
    logic        tbl_ack, cpu_stall, fl_rd, fl_wstb, fl_erase, fl_prog, fl_done;
    logic [1:0]  sfr_sel;
    logic [7:0]  page, page_rdata, busy;
    logic [15:0] sfr_wdata, tbl_ea, tbl_wdata, ctrl_rdata, tbl_rdata, base, rd, ea;
    logic [23:0] fl_addr, fl_rdata, fl_wdata, w;
    logic [23:0] mem_m [int];
    logic [23:0] latch_m [64];
    int          failures, checks_done, j;

    sfc_flash_ctrl u_dut (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .SFR_WE_I(sfr_we), .SFR_SEL_I(sfr_sel), .SFR_WDATA_I(sfr_wdata),
        .CTRL_RDATA_O(ctrl_rdata), .PAGE_RDATA_O(page_rdata), .TBL_REQ_I(tbl_req), .TBL_WRITE_I(tbl_write),
        .TBL_HIGH_I(tbl_high), .TBL_BYTE_I(tbl_byte), .TBL_EA_I(tbl_ea), .TBL_WDATA_I(tbl_wdata),
        .TBL_RDATA_O(tbl_rdata), .TBL_ACK_O(tbl_ack), .CPU_STALL_O(cpu_stall), .FL_ADDR_O(fl_addr),
        .FL_RD_O(fl_rd), .FL_RDATA_I(fl_rdata), .FL_WSTB_O(fl_wstb), .FL_WDATA_O(fl_wdata),
        .FL_ERASE_O(fl_erase), .FL_PROG_O(fl_prog), .FL_DONE_I(fl_done)
    );
    sfc_flash_model u_flash (
        .clk_i(clk), .addr_i(fl_addr), .rd_i(fl_rd), .wstb_i(fl_wstb), .wdata_i(fl_wdata),
        .erase_i(fl_erase), .prog_i(fl_prog), .busy_i(busy), .rdata_o(fl_rdata), .done_o(fl_done)
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Reference read value from the bench's copy of the array, mem_m
    function automatic logic [15:0] expect_rd(input logic [23:0] a, input logic h, b);
        logic [23:0] v;
        v = mem_m.exists(int'({a[23:1], 1'b0})) ? mem_m[int'({a[23:1], 1'b0})] : 24'hffffff;
        if (h) return (b && a[0]) ? 16'h0000 : {8'h00, v[23:16]};
        return b ? {8'h00, a[0] ? v[15:8] : v[7:0]} : v[15:0];
    endfunction

    task automatic sfr(input logic [1:0] sel, input logic [15:0] d);
        @(negedge clk);
        {sfr_we, sfr_sel, sfr_wdata} = {1'b1, sel, d};
        @(negedge clk);
        sfr_we = 1'b0;
    endtask

    task automatic tbl(input logic wr, h, b, input logic [15:0] a, d, input logic ack_exp);
        @(negedge clk);
        {tbl_req, tbl_write, tbl_high, tbl_byte, tbl_ea, tbl_wdata} = {1'b1, wr, h, b, a, d};
        @(negedge clk);
        tbl_req = 1'b0;
        for (int n = 0; n < 4 && tbl_ack !== 1'b1; n++) @(negedge clk);
        `CHK("table ack", ack_exp, tbl_ack)
        rd = tbl_rdata;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic h, b);
        tbl(1'b0, h, b, a, 16'h0000, 1'b1);
        `CHK("table read", expect_rd({page, a}, h, b), (b && !h) ? {8'h00, rd[7:0]} : rd)
    endtask

    // keys then start with no other traffic
    task automatic launch(input logic [15:0] ctl);
        sfr(SEL_KEY, {8'h00, KEY_FIRST});
        sfr(SEL_KEY, {8'h00, KEY_SECOND});
        sfr(SEL_CTRL, ctl | 16'h8000); // Final control write carries the start bit
        `CHK("cycle started", 2'b11, {cpu_stall, ctrl_rdata[CTL_START]})
    endtask

    // core stays quiet until the cycle ends
    task automatic wait_idle();
        for (int n = 0; n < 400 && cpu_stall !== 1'b0; n++) @(negedge clk);
        `CHK("cycle ended", 2'b00, {cpu_stall, ctrl_rdata[CTL_START]})
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        failures++;
        conclude();
    end

    // Main sequence: row program, erase, byte-patched word program, refused starts
    initial begin
        failures = 0;
        checks_done = 0;
        {rst_n, sfr_we, tbl_req, tbl_write, tbl_high, tbl_byte, sfr_sel, sfr_wdata, tbl_ea, tbl_wdata} = '0;
        busy = 8'h01;
        j = $urandom(92412);
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        `CHK("reset state", {CTL_RESET, 8'h00, 1'b0}, {ctrl_rdata, page_rdata, cpu_stall})
        page = 8'($urandom);
        base = 16'($urandom) & 16'hff80;
        j = $urandom_range(63, 0);
        sfr(SEL_PAGE, {8'h00, page});
        `CHK("page register", page, page_rdata)
        for (int i = 0; i < 64; i++) begin
            latch_m[i] = 24'($urandom);
            tbl(1'b1, 1'b0, 1'b0, base + 16'(2 * i), latch_m[i][15:0], 1'b1);
            tbl(1'b1, 1'b1, 1'b0, base + 16'(2 * i), {8'h00, latch_m[i][23:16]}, 1'b1);
        end
        launch(16'h4001);
        wait_idle();
        for (int i = 0; i < 64; i++) begin
            mem_m[int'({page, base}) + 2 * i] = latch_m[i];
            rdchk(base + 16'(2 * i), 1'b0, 1'b0);
            rdchk(base + 16'(2 * i), 1'b1, 1'b0);
        end
        // page base through a table write, then erase
        tbl(1'b1, 1'b0, 1'b0, base, 16'h0000, 1'b1);
        latch_m[0][15:0] = 16'h0000;
        busy = 8'h1e;
        launch(16'h4042);
        `CHK("erase select", 1'b1, fl_erase)
        sfr(SEL_PAGE, {8'h00, ~page});
        tbl(1'b1, 1'b0, 1'b0, base, 16'h0000, 1'b0);
        wait_idle();
        `CHK("page held", page, page_rdata)
        for (int i = 0; i < 1024; i += 2) mem_m.delete(int'({page, base & 16'hfc00}) + i);
        rdchk(base + 16'(2 * j), 1'b0, 1'b0);
        rdchk(base & 16'hfc00, 1'b1, 1'b0);
        ea = base + 16'(2 * j) + 16'h0001;
        w = 24'($urandom);
        tbl(1'b1, 1'b0, 1'b1, ea, {8'h00, w[7:0]}, 1'b1);
        tbl(1'b1, 1'b1, 1'b1, ea, 16'h00ff, 1'b1);
        latch_m[j][15:8] = w[7:0];
        busy = 8'h01;
        launch(16'h4003);
        wait_idle();
        mem_m[int'({page, ea}) - 1] = latch_m[j];
        for (int m = 0; m < 8; m++) rdchk(ea - 16'(m[0]), m[1], m[2]);
        for (int k = 0; k < 3; k++) begin
            if (k > 0) sfr(SEL_KEY, {8'h00, KEY_FIRST});
            if (k > 0) sfr(SEL_KEY, {8'h00, KEY_SECOND});
            if (k == 1) sfr(2'h3, 16'h0000);
            sfr(SEL_CTRL, k == 2 ? 16'h8001 : 16'hc001);
            `CHK("refused start", 2'b00, {cpu_stall, ctrl_rdata[CTL_START]})
        end
        sfr(SEL_KEY, {8'h00, KEY_FIRST});
        sfr(SEL_KEY, {8'h00, KEY_SECOND});
        sfr(SEL_CTRL, 16'hc005);
        `CHK("bad opcode", 2'b01, {cpu_stall, ctrl_rdata[CTL_ERR]})
        sfr(SEL_CTRL, 16'h0000);
        `CHK("error cleared", 16'h0000, ctrl_rdata)
        conclude();
    end
endmodule
